// [verilog/paper_sense_defines.svh]
// Constants of the paper sense and general pin unit: offsets, field positions, reset values.
// Assumes inclusion by bare name from every file that needs them.
`ifndef PAPER_SENSE_DEFINES_SVH
`define PAPER_SENSE_DEFINES_SVH

// Pin counts and the widths of the register address, line count and interrupt fields.
`define NUM_SENSE 2
`define NUM_GPIO 6
`define NUM_PINS 8
`define ADDR_W 8
`define LINES_W 16
`define IRQ_W 10

// Byte addresses of the register words.
`define ADDR_STATUS 8'h00
`define ADDR_DIR 8'h04
`define ADDR_POL 8'h08
`define ADDR_EDGE 8'h0c
`define ADDR_OUT 8'h10
`define ADDR_SENSE_CTRL 8'h14
`define ADDR_PS2_LINES 8'h18
`define ADDR_IRQ_STATUS 8'h1c
`define ADDR_IRQ_MASK 8'h20

// Field positions.
`define STATUS_PS1_BIT 0
`define STATUS_PS2_BIT 1
`define STATUS_GPIO_LSB 2
`define CTRL_PS1_STOP_BIT 0
`define CTRL_PS2_STOP_BIT 1
`define IRQ_PS1_STOP_BIT 8
`define IRQ_PS2_FIRE_BIT 9

// Reset values.
`define RST_DIR 6'h38
`define RST_POL 8'he3
`define RST_EDGE 8'h1c
`define RST_OUT 6'h18
`define RST_SENSE_CTRL 2'h0
`define RST_PS2_LINES 16'h0000
`define RST_IRQ_MASK 10'h000

// Bus response codes.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// [verilog/paper_sense_pkg.sv]
// Types shared by the paper sense and general pin unit.
// Assumes the defines header is on the include path.
`include "paper_sense_defines.svh"

package paper_sense_pkg;

  // Motion command currently executed by the scan engine outside this unit.
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_SCAN = 2'b01,
    MODE_FWD = 2'b11,
    MODE_REV = 2'b10
  } scan_mode_t;

  // Delayed action of the second sensor, Gray coded along idle, count, fire.
  typedef enum logic [1:0] {
    PS2_IDLE = 2'b00,
    PS2_COUNT = 2'b01,
    PS2_FIRE = 2'b11
  } ps2_state_t;

  // Per-pin configuration held by software.
  typedef struct packed {
    logic [`NUM_GPIO-1:0] dir;
    logic [`NUM_PINS-1:0] pol;
    logic [`NUM_PINS-1:0] edge_sel;
    logic [`NUM_GPIO-1:0] out;
  } pin_cfg_t;

endpackage : paper_sense_pkg

// [verilog/pin_sampler.sv]
// Input stage: two-flop synchroniser, polarity, and false-to-true detection per pin.
// Assumes pins may change at any time relative to clk_i.
`timescale 1ns/1ps

module pin_sampler #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  input wire logic [WIDTH-1:0] pol_i,
  output logic [WIDTH-1:0] true_o,
  output logic [WIDTH-1:0] rise_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] true_reg;
  logic [WIDTH-1:0] true_next;
  logic [2:0] warm_reg;

  // The first stage feeds only the second, so a metastable value never reaches logic.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
    end
  end

  // Active-high polarity passes the level, active-low inverts it.
  assign true_next = ~(sync_reg ^ pol_i);

  // The previous sample lets a transition be seen as a pair of consecutive samples.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      true_reg <= '0;
    end else begin
      true_reg <= true_next;
    end
  end

  // Outputs: current true state and a one-cycle pulse on each false-to-true step.
  assign true_o = true_reg;
  assign rise_o = true_next & ~true_reg & {WIDTH{warm_reg[2]}};

  // Steps are ignored until the stages hold real pin levels, else an active-low pin
  // would show a false step just after reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      warm_reg <= '0;
    end else begin
      warm_reg <= {warm_reg[1:0], 1'b1};
    end
  end

endmodule : pin_sampler

// [verilog/paper_sense_io.sv]
// Paper sense and general pin unit with an AXI4-Lite register slave and one interrupt.
// Assumes scan_mode_i comes from the command logic, which clears its own scan bit
// when scan_stop_o pulses, and line_end_i pulses once per line from the pixel counter.
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "paper_sense_defines.svh"

module paper_sense_io #(
  parameter int LINES_W = `LINES_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic suspend_i,
  input wire logic soft_reset_i,
  input wire paper_sense_pkg::scan_mode_t scan_mode_i,
  input wire logic line_end_i,
  output logic scan_stop_o,
  input wire logic [`NUM_SENSE-1:0] sense_i,
  input wire logic [`NUM_GPIO-1:0] gpio_in_i,
  output logic [`NUM_GPIO-1:0] gpio_out_o,
  output logic [`NUM_GPIO-1:0] gpio_oe_n_o,
  output logic irq_o,
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import paper_sense_pkg::*;

  // Field widths as constants, so that a merged word is cut to size by a cast.
  localparam int GPIO_N = `NUM_GPIO;
  localparam int PINS_N = `NUM_PINS;
  localparam int IRQ_N = `IRQ_W;

  // Word decode, shared by the read and the write path.
  function automatic logic is_mapped(input logic [`ADDR_W-1:0] addr);
    unique case ({addr[`ADDR_W-1:2], 2'b00})
      `ADDR_STATUS, `ADDR_DIR, `ADDR_POL, `ADDR_EDGE, `ADDR_OUT,
      `ADDR_SENSE_CTRL, `ADDR_PS2_LINES, `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK: begin
        is_mapped = 1'b1;
      end
      default: begin
        is_mapped = 1'b0;
      end
    endcase
  endfunction : is_mapped

  // Merges write data into an old value, one byte lane per strobe bit.
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  pin_cfg_t cfg_reg;
  logic [1:0] sense_ctrl_reg;
  logic [LINES_W-1:0] ps2_lines_reg;
  logic [LINES_W-1:0] line_cnt_reg;
  ps2_state_t ps2_state_reg;
  ps2_state_t ps2_state_next;
  logic ps2_flag_reg;
  logic ps1_prev_reg;
  logic [`NUM_PINS-1:0] edge_flag_reg;
  logic [`IRQ_W-1:0] irq_status_reg;
  logic [`IRQ_W-1:0] irq_mask_reg;
  logic stop_reg;

  logic aw_full_reg;
  logic w_full_reg;
  logic [`ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  logic [`NUM_PINS-1:0] pin_true;
  logic [`NUM_PINS-1:0] pin_rise;
  logic [`NUM_PINS-1:0] input_mask;
  logic [`NUM_PINS-1:0] status_val;
  logic pin_rst;
  logic do_write;
  logic ar_take;
  logic status_rd;
  logic irq_rd;
  logic ps1_trig;
  logic ps2_fire;
  logic [`IRQ_W-1:0] irq_event;
  logic [`ADDR_W-1:0] w_word;
  logic [`ADDR_W-1:0] r_word;

  // All eight pins share one input stage; output pins are sampled too but their steps are masked below.
  pin_sampler #(
    .WIDTH(`NUM_PINS)
  ) u_sampler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({gpio_in_i, sense_i}),
    .pol_i(cfg_reg.pol),
    .true_o(pin_true),
    .rise_o(pin_rise)
  );

  // Sensor pins are always inputs; a general pin is an input while its direction bit is 0.
  assign input_mask = {~cfg_reg.dir, {`NUM_SENSE{1'b1}}};

  // Pin defaults come back on the reset pin and on suspend, but never on soft reset.
  assign pin_rst = rst_i | suspend_i;

  // Status view: edge-mode bits show the captured flag, level-mode bits the live state; with the sensor-two stop on, bit 1 shows its delayed flag.
  always_comb begin
    for (int i = 0; i < `NUM_PINS; i++) begin
      status_val[i] = cfg_reg.edge_sel[i] ? edge_flag_reg[i] : pin_true[i];
    end
    if (sense_ctrl_reg[`CTRL_PS2_STOP_BIT]) begin
      status_val[`STATUS_PS2_BIT] = ps2_flag_reg;
    end
  end

  // Bus handshakes: one write and one read in flight; address and data taken in any order.
  assign s_axi_awready = ~aw_full_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_full_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign w_word = {aw_addr_reg[`ADDR_W-1:2], 2'b00};
  assign ar_take = s_axi_arvalid & ~rvalid_reg;
  assign r_word = {s_axi_araddr[`ADDR_W-1:2], 2'b00};
  assign status_rd = ar_take & (r_word == `ADDR_STATUS);
  assign irq_rd = ar_take & (r_word == `ADDR_IRQ_STATUS);

  // Write address and data holding stages.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  // Write response; unmapped words answer with a slave error.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= is_mapped(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Pin configuration is writable whenever reset and suspend are low; the command state does not gate it.
  always_ff @(posedge clk_i) begin
    if (pin_rst) begin
      cfg_reg.dir <= `RST_DIR;
      cfg_reg.pol <= `RST_POL;
      cfg_reg.edge_sel <= `RST_EDGE;
      cfg_reg.out <= `RST_OUT;
    end else if (do_write) begin
      unique case (w_word)
        `ADDR_DIR: begin
          cfg_reg.dir <= GPIO_N'(merge(32'(cfg_reg.dir), w_data_reg, w_strb_reg));
        end
        `ADDR_POL: begin
          cfg_reg.pol <= PINS_N'(merge(32'(cfg_reg.pol), w_data_reg, w_strb_reg));
        end
        `ADDR_EDGE: begin
          cfg_reg.edge_sel <= PINS_N'(merge(32'(cfg_reg.edge_sel), w_data_reg,
                                            w_strb_reg));
        end
        `ADDR_OUT: begin
          cfg_reg.out <= GPIO_N'(merge(32'(cfg_reg.out), w_data_reg, w_strb_reg));
        end
        default: begin
        end
      endcase
    end
  end

  // Sensor control and line count share the pin reset, as they belong to the same group.
  always_ff @(posedge clk_i) begin
    if (pin_rst) begin
      sense_ctrl_reg <= `RST_SENSE_CTRL;
      ps2_lines_reg <= LINES_W'(`RST_PS2_LINES);
      irq_mask_reg <= `RST_IRQ_MASK;
    end else if (do_write) begin
      unique case (w_word)
        `ADDR_SENSE_CTRL: begin
          sense_ctrl_reg <= 2'(merge(32'(sense_ctrl_reg), w_data_reg, w_strb_reg));
        end
        `ADDR_PS2_LINES: begin
          ps2_lines_reg <= LINES_W'(merge(32'(ps2_lines_reg), w_data_reg,
                                          w_strb_reg));
        end
        `ADDR_IRQ_MASK: begin
          irq_mask_reg <= IRQ_N'(merge(32'(irq_mask_reg), w_data_reg, w_strb_reg));
        end
        // Writes to the status words are dropped, so they cannot disturb the flags.
        default: begin
        end
      endcase
    end
  end

  // Edge flags: a read clears them, but a step in the same cycle still wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_flag_reg <= '0;
    end else begin
      edge_flag_reg <= (edge_flag_reg & ~{`NUM_PINS{status_rd}})
                       | (pin_rise & input_mask);
    end
  end

  // Sensor one acts on its reported state, so in edge mode the flag's rise counts.
  assign ps1_trig = sense_ctrl_reg[`CTRL_PS1_STOP_BIT]
                    & status_val[`STATUS_PS1_BIT] & ~ps1_prev_reg;

  // Previous reported state of sensor one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ps1_prev_reg <= 1'b0;
    end else begin
      ps1_prev_reg <= status_val[`STATUS_PS1_BIT];
    end
  end

  // Sensor two delay: arm on the pin's rise, count line ends, fire at the programmed count.
  always_comb begin
    ps2_state_next = ps2_state_reg;
    unique case (ps2_state_reg)
      PS2_IDLE: begin
        if (sense_ctrl_reg[`CTRL_PS2_STOP_BIT] & pin_rise[`STATUS_PS2_BIT]) begin
          ps2_state_next = (ps2_lines_reg == '0) ? PS2_FIRE : PS2_COUNT;
        end
      end
      PS2_COUNT: begin
        if (line_end_i & (line_cnt_reg + LINES_W'(1) == ps2_lines_reg)) begin
          ps2_state_next = PS2_FIRE;
        end
      end
      PS2_FIRE: begin
        ps2_state_next = PS2_IDLE;
      end
      default: begin
        ps2_state_next = PS2_IDLE;
      end
    endcase
  end

  assign ps2_fire = (ps2_state_reg == PS2_FIRE);

  // Soft reset abandons a pending delay but leaves every pin setting alone.
  always_ff @(posedge clk_i) begin
    if (rst_i | soft_reset_i) begin
      ps2_state_reg <= PS2_IDLE;
      line_cnt_reg <= '0;
    end else begin
      ps2_state_reg <= ps2_state_next;
      if (ps2_state_reg != PS2_COUNT) begin
        line_cnt_reg <= '0;
      end else if (line_end_i) begin
        line_cnt_reg <= line_cnt_reg + LINES_W'(1);
      end
    end
  end

  // Delayed status of sensor two: set on fire, cleared by a status read, set wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ps2_flag_reg <= 1'b0;
    end else begin
      ps2_flag_reg <= (ps2_flag_reg & ~status_rd) | ps2_fire;
    end
  end

  // Stop request to the command logic; reverse moves only answer to sensor one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_reg <= 1'b0;
    end else begin
      stop_reg <= (ps1_trig & (scan_mode_i != MODE_IDLE))
                  | (ps2_fire & ((scan_mode_i == MODE_SCAN)
                                 | (scan_mode_i == MODE_FWD)));
    end
  end

  assign scan_stop_o = stop_reg;

  // Interrupt events: each input's rise, the sensor-one stop, and the sensor-two fire.
  assign irq_event = {ps2_fire, ps1_trig, pin_rise & input_mask};

  // Sticky interrupt status, cleared by its own read; a new event in that cycle survives.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~{`IRQ_W{irq_rd}}) | irq_event;
    end
  end

  // Level interrupt, high while any unmasked status bit stands.
  assign irq_o = |(irq_status_reg & irq_mask_reg);

  // Read path: data captured at the address handshake; unmapped words read zero with error.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= `RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (r_word)
        `ADDR_STATUS: rdata_reg <= 32'(status_val);
        `ADDR_DIR: rdata_reg <= 32'(cfg_reg.dir);
        `ADDR_POL: rdata_reg <= 32'(cfg_reg.pol);
        `ADDR_EDGE: rdata_reg <= 32'(cfg_reg.edge_sel);
        `ADDR_OUT: rdata_reg <= 32'(cfg_reg.out);
        `ADDR_SENSE_CTRL: rdata_reg <= 32'(sense_ctrl_reg);
        `ADDR_PS2_LINES: rdata_reg <= 32'(ps2_lines_reg);
        `ADDR_IRQ_STATUS: rdata_reg <= 32'(irq_status_reg);
        `ADDR_IRQ_MASK: rdata_reg <= 32'(irq_mask_reg);
        default: rdata_reg <= '0;
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Output pins follow their register bits; the enable is low while a pin is driven.
  assign gpio_out_o = cfg_reg.out;
  assign gpio_oe_n_o = ~cfg_reg.dir;

endmodule : paper_sense_io

// [dv/sensor_panel_model.sv]
// Behavioural model of the sensors, buttons and lamps wired to the sense and general pins.
// Assumes the bench sets sensor and button levels; a released general line rests on its pull-up.
`timescale 1ns/1ps

module sensor_panel_model (
  input wire logic [1:0] sense_lvl_i,
  input wire logic [5:0] button_lvl_i,
  input wire logic [5:0] gpio_out_i,
  input wire logic [5:0] gpio_oe_n_i,
  output logic [1:0] sense_o,
  output logic [5:0] gpio_wire_o
);
  // Sensors are push-pull, so their lines always carry a level.
  assign sense_o = sense_lvl_i;
  // A driven pin shows the unit's level; a released one shows the button and pull-up.
  assign gpio_wire_o = (~gpio_oe_n_i & gpio_out_i) | (gpio_oe_n_i & button_lvl_i);
endmodule : sensor_panel_model

// [dv/paper_sense_io_monitor.sv]
// Concurrent checks on the ports of the paper sense and general pin unit.
// Assumes it is bound to the unit and shares its single clock and reset.
`timescale 1ns/1ps
`include "paper_sense_defines.svh"

module paper_sense_io_monitor
  import paper_sense_pkg::*;
#(
  parameter int LINES_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic suspend_i,
  input wire paper_sense_pkg::scan_mode_t scan_mode_i,
  input wire logic scan_stop_o,
  input wire logic [`NUM_GPIO-1:0] gpio_out_o,
  input wire logic [`NUM_GPIO-1:0] gpio_oe_n_o,
  input wire logic irq_o,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking mon_clk @(posedge clk_i);
  endclocking

  // Reset and suspend force the default pin drive by the next edge.
  property p_pin_defaults;
    (rst_i || suspend_i) |=> gpio_out_o == 6'h18 && gpio_oe_n_o == 6'h07;
  endproperty
  a_pin_defaults: assert property (p_pin_defaults)
    else $error("pins not at defaults after reset or suspend");

  // Pin drive moves only with a register write, so soft reset cannot disturb it.
  property p_pins_by_write;
    disable iff (rst_i)
    ($changed(gpio_out_o) || $changed(gpio_oe_n_o)) && !$past(rst_i) && !$past(suspend_i)
      |-> $rose(s_axi_bvalid);
  endproperty
  a_pins_by_write: assert property (p_pins_by_write)
    else $error("pin drive changed without a write");

  property p_irq_reset;
    rst_i |=> !irq_o;
  endproperty
  a_irq_reset: assert property (p_irq_reset)
    else $error("interrupt high after reset");

  // Responses stand until the master takes them.
  property p_b_hold;
    disable iff (rst_i) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");

  property p_r_hold;
    disable iff (rst_i) s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");

  property p_r_latency;
    disable iff (rst_i) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_latency: assert property (p_r_latency)
    else $error("read answer not one cycle after address");

  property p_unmapped;
    disable iff (rst_i)
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h08
      |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");

  // A stop request is a single pulse and is never raised while idle.
  property p_stop_single;
    disable iff (rst_i) scan_stop_o |=> !scan_stop_o;
  endproperty
  a_stop_single: assert property (p_stop_single)
    else $error("stop pulse longer than one cycle");

  property p_stop_mode;
    disable iff (rst_i) scan_stop_o |-> $past(scan_mode_i) != MODE_IDLE;
  endproperty
  a_stop_mode: assert property (p_stop_mode)
    else $error("stop raised with no move under way");
endmodule : paper_sense_io_monitor

bind paper_sense_io paper_sense_io_monitor #(.LINES_W(LINES_W)) paper_sense_io_monitor_inst (
  .clk_i(clk_i), .rst_i(rst_i), .suspend_i(suspend_i), .scan_mode_i(scan_mode_i),
  .scan_stop_o(scan_stop_o), .gpio_out_o(gpio_out_o), .gpio_oe_n_o(gpio_oe_n_o),
  .irq_o(irq_o), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// [dv/tb_top.sv]
// Self-checking bench for the paper sense and general pin unit, driven over its register bus.
// Assumes the design, the panel model and the monitor are compiled before this file.
`timescale 1ns/1ps

module tb_top;
  import paper_sense_pkg::*;
  logic clk_i = 0, rst_i = 1, suspend_i = 0, soft_reset_i = 0, line_end_i = 0;
  scan_mode_t scan_mode_i = MODE_IDLE;
  logic [1:0] sense_i, r, sense_lvl = 2'h0;
  logic [5:0] gpio_in_i, gpio_out_o, gpio_oe_n_o, button_lvl = 6'h3f;
  logic scan_stop_o, irq_o, awready, wready, bvalid, arready, rvalid;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [3:0] wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp;
  int n_mismatch = 0, compares = 0, cycles = 0, cnt;
  logic [7:0] cfg_addr[7] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20};
  logic [31:0] cfg_rst[7] = '{32'h38, 32'he3, 32'h1c, 32'h18, 32'h0, 32'h0, 32'h0};
  scan_mode_t modes[4] = '{MODE_SCAN, MODE_FWD, MODE_REV, MODE_IDLE};
  logic [31:0] stop1[4] = '{32'h1, 32'h1, 32'h1, 32'h0};
  logic [31:0] stop2[4] = '{32'h1, 32'h1, 32'h0, 32'h0};

  paper_sense_io #(.LINES_W(16)) paper_sense_io_inst (
    .clk_i(clk_i), .rst_i(rst_i), .suspend_i(suspend_i), .soft_reset_i(soft_reset_i),
    .scan_mode_i(scan_mode_i), .line_end_i(line_end_i), .scan_stop_o(scan_stop_o),
    .sense_i(sense_i), .gpio_in_i(gpio_in_i), .gpio_out_o(gpio_out_o),
    .gpio_oe_n_o(gpio_oe_n_o), .irq_o(irq_o), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  sensor_panel_model sensor_panel_model_inst (
    .sense_lvl_i(sense_lvl), .button_lvl_i(button_lvl), .gpio_out_i(gpio_out_o),
    .gpio_oe_n_i(gpio_oe_n_o), .sense_o(sense_i), .gpio_wire_o(gpio_in_i)
  );

  // Free-running clock and a watchdog well above the expected run of a few hundred cycles.
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic final_report();
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // Address, data and bready go out together; each is held until its own handshake edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    bit done;
    done = 0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!done) begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 0;
        done = 1;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    bit done;
    done = 0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!done) begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid && rready) begin
        v = rdata;
        resp = rresp;
        rready <= 0;
        done = 1;
      end
    end
  endtask : rd

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    rd(a, d, r);
    check(nm, exp, d);
  endtask : rd_chk

  task automatic watch_stop(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk_i);
      if (scan_stop_o === 1'b1) c++;
    end
  endtask : watch_stop

  task automatic line_pulse();
    @(posedge clk_i);
    line_end_i <= 1;
    @(posedge clk_i);
    line_end_i <= 0;
  endtask : line_pulse

  // Main sequence; the status words are only ever read, though writes to them are dropped.
  initial begin
    tick(12);
    rst_i <= 0;
    tick(4);
    rd_chk("status at reset", 8'h00, 32'h60);
    rd_chk("irq status at reset", 8'h1c, 32'h000);
    foreach (cfg_addr[i]) rd_chk("reset value", cfg_addr[i], cfg_rst[i]);
    check("out at reset", 32'h18, {26'h0, gpio_out_o});
    check("oe_n at reset", 32'h07, {26'h0, gpio_oe_n_o});
    rd(8'h24, d, r);
    check("unmapped rresp", 32'h2, {30'h0, r});
    wr(8'h28, 32'h5a, r);
    check("unmapped bresp", 32'h2, {30'h0, r});
    $display("test reset_defaults done");
    sense_lvl <= 2'h3;
    tick(5);
    rd_chk("status level", 8'h00, 32'h63);
    wr(8'h08, 32'he2, r);
    tick(5);
    rd_chk("status polarity", 8'h00, 32'h62);
    wr(8'h20, 32'h8, r);
    button_lvl <= 6'h3d;
    tick(5);
    check("irq raised", 32'h1, {31'h0, irq_o});
    button_lvl <= 6'h3f;
    tick(5);
    rd_chk("status edge", 8'h00, 32'h6a);
    rd_chk("status cleared", 8'h00, 32'h62);
    rd_chk("irq status", 8'h1c, 32'h00b);
    tick(1);
    check("irq cleared", 32'h0, {31'h0, irq_o});
    wr(8'h20, 32'h0, r);
    button_lvl <= 6'h3d;
    tick(5);
    check("irq masked", 32'h0, {31'h0, irq_o});
    button_lvl <= 6'h3f;
    tick(5);
    rd_chk("irq status masked", 8'h1c, 32'h008);
    $display("test sense_edge_irq done");
    wr(8'h04, 32'h3f, r);
    wr(8'h10, 32'h05, r);
    check("oe_n all out", 32'h00, {26'h0, gpio_oe_n_o});
    check("out levels", 32'h05, {26'h0, gpio_out_o});
    wr(8'h04, 32'h00, r);
    check("oe_n all in", 32'h3f, {26'h0, gpio_oe_n_o});
    tick(5);
    rd(8'h00, d, r);
    rd_chk("status inputs", 8'h00, 32'he2);
    wr(8'h04, 32'h38, r);
    wr(8'h10, 32'h1f, r);
    wr(8'h08, 32'he3, r);
    $display("test direction done");
    wr(8'h14, 32'h1, r);
    for (int i = 0; i < 4; i++) begin
      sense_lvl[0] <= 0;
      tick(5);
      scan_mode_i <= modes[i];
      sense_lvl[0] <= 1;
      watch_stop(10, cnt);
      check("stop sensor1", stop1[i], cnt);
    end
    $display("test sensor1_stop done");
    wr(8'h14, 32'h2, r);
    wr(8'h18, 32'h2, r);
    for (int i = 0; i < 4; i++) begin
      sense_lvl[1] <= 0;
      soft_reset_i <= 1;
      tick(1);
      soft_reset_i <= 0;
      tick(5);
      rd(8'h00, d, r);
      check("out after soft reset", 32'h1f, {26'h0, gpio_out_o});
      scan_mode_i <= modes[i];
      sense_lvl[1] <= 1;
      tick(5);
      line_pulse();
      watch_stop(6, cnt);
      check("early stop sensor2", 32'h0, cnt);
      line_pulse();
      watch_stop(6, cnt);
      check("stop sensor2", stop2[i], cnt);
      rd_chk("status sensor2", 8'h00, 32'h63);
    end
    $display("test sensor2_delay done");
    wr(8'h14, 32'h0, r);
    wr(8'h10, 32'h00, r);
    check("out written", 32'h00, {26'h0, gpio_out_o});
    suspend_i <= 1;
    tick(2);
    suspend_i <= 0;
    tick(2);
    check("out after suspend", 32'h18, {26'h0, gpio_out_o});
    rd_chk("out reg after suspend", 8'h10, 32'h18);
    $display("test suspend done");
    final_report();
  end
endmodule : tb_top
